// >>> verilog/dcm_pkg.sv
`default_nettype none
package dcm_pkg;
  // Command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DESEL = 4'hf;
  // Address and mode register fields
  localparam int AP_BIT = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_TM_BIT = 7;
  localparam int MR_DLLRST_BIT = 8;
  localparam int MR_WR_LSB = 9;
  localparam int EMR_DLLDIS_BIT = 0;
  localparam int EMR_OCD_LSB = 7;
  localparam logic [2:0] OCD_DEFAULT = 3'h7;
  localparam logic [2:0] OCD_EXIT = 3'h0;
  localparam logic [2:0] BL_CODE8 = 3'h3;
  localparam logic [2:0] MR_WR_CODE = 3'h1;
  localparam logic [2:0] SEL_MR = 3'h0;
  localparam logic [2:0] SEL_EMR1 = 3'h1;
  localparam logic [2:0] SEL_EMR2 = 3'h2;
  localparam logic [2:0] SEL_EMR3 = 3'h3;
  // Timing
  localparam int CLK_NS = 20;
  localparam int T_POWER_US = 200;
  localparam int T_CKE_NS = 400;
  localparam int T_CAC_NS = 50;
  localparam int T_RP_NS = 15;
  localparam int T_RCD_NS = 15;
  localparam int T_RFC_NS = 128;
  localparam int T_WR_NS = 15;
  localparam int POWER_CYC_DEF = T_POWER_US * 1000 / CLK_NS;
  localparam int CKE_CYC = (T_CKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CL_CYC = (T_CAC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RFC_CYC = (T_RFC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int MRD_CYC = 2;
  localparam int XP_CYC = 2;
  localparam int DLL_LOCK_CYC = 200;
  localparam int INIT_LAST = 11;
  // Controller registers on the Avalon-MM slave
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_ADDR = 5'h08;
  localparam logic [4:0] REG_WDATA = 5'h0c;
  localparam logic [4:0] REG_RDATA = 5'h10;
  localparam logic [4:0] REG_CMD = 5'h14;
  localparam logic [4:0] REG_MODE = 5'h18;
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_PD_BIT = 1;
  localparam int CTRL_SR_BIT = 2;
  localparam int ADDR_COL_LSB = 0;
  localparam int ADDR_ROW_LSB = 10;
  localparam int ADDR_BANK_LSB = 23;
  localparam int OP_RD_BIT = 0;
  localparam int OP_WR_BIT = 1;
  localparam int OP_AP_BIT = 2;
  localparam logic [3:0] MODE_RST = 4'h2;
endpackage
`default_nettype wire

// >>> verilog/dcm_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dcm_link_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic odt;
  logic [2:0] ba;
  logic [12:0] a;
  logic [1:0] dm;
  logic [15:0] ctrl_dq;
  logic ctrl_dq_oe;
  logic [15:0] dev_dq;
  logic dev_dq_oe;
  logic [15:0] dq;
  // Shared data wire resolved from the two enables; undriven reads as zero
  assign dq = dev_dq_oe ? dev_dq : (ctrl_dq_oe ? ctrl_dq : 16'h0000);
  modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, odt, ba, a, dm, ctrl_dq, ctrl_dq_oe,
                input dq);
  modport dev (input cs_n, ras_n, cas_n, we_n, cke, odt, ba, a, dm, dq,
               output dev_dq, dev_dq_oe);
endinterface
`default_nettype wire

// >>> verilog/dcm_dram.sv
`timescale 1ns/10ps
`default_nettype none
module dcm_dram #(
  parameter int MEM_AW = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link
  dcm_link_if.dev link,
  // Status
  output logic [12:0] mr_o,
  output logic mr_valid_o,
  output logic pd_o,
  output logic sr_o,
  output logic dll_ready_o,
  output logic err_o
);
  if (MEM_AW < 4 || MEM_AW > 20) begin : g_chk
    $error("MEM_AW out of range");
  end

  typedef enum logic [2:0] {D_ON = 3'b001, D_PD = 3'b010, D_SR = 3'b100} dcm_pwr_type;

  logic [15:0] mem_q [2**MEM_AW];
  logic [12:0] mreg_q [4];
  logic [12:0] mreg_d [4];
  logic [12:0] row_q [8];
  logic [12:0] row_d [8];
  dcm_pwr_type pwr_q, pwr_d;
  logic [3:0] mval_q, mval_d;
  logic [7:0] open_q, open_d;
  logic cke_prev_q, err_q, err_d, bact_q, bact_d, bwr_q, bwr_d, bap_q, bap_d;
  logic [2:0] bbank_q, bbank_d;
  logic [9:0] bcol_q, bcol_d;
  logic [4:0] dt_q, dt_d;
  logic [7:0] dll_q, dll_d;
  logic [15:0] dq_q, dq_d;
  logic dqoe_q, dqoe_d;
  logic [3:0] cmd;
  logic nopish, bl8;
  logic [4:0] cl, bl, beat;
  logic [2:0] ord;
  logic [MEM_AW-1:0] idx;
  logic [1:0] mwe;

  assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
  assign nopish = link.cs_n | (cmd == dcm_pkg::CMD_NOP);
  assign cl = {2'b00, mreg_q[0][dcm_pkg::MR_CL_LSB +: 3]};
  assign bl8 = mreg_q[0][dcm_pkg::MR_BL_LSB +: 3] == dcm_pkg::BL_CODE8;
  assign bl = bl8 ? 5'd8 : 5'd4;
  assign beat = dt_q - (cl - 5'd1);

  // Sequential wraps inside the burst block; interleaved xors the beat in
  always_comb begin
    if (mreg_q[0][dcm_pkg::MR_BT_BIT]) begin
      ord = bcol_q[2:0] ^ {bl8 & beat[2], beat[1:0]};
    end else if (bl8) begin
      ord = bcol_q[2:0] + beat[2:0];
    end else begin
      ord = {bcol_q[2], bcol_q[1:0] + beat[1:0]};
    end
  end
  // Small array: row and column alias above MEM_AW bits
  assign idx = MEM_AW'({row_q[bbank_q], bcol_q[9:3], ord});

  always_comb begin
    pwr_d = pwr_q;
    mreg_d = mreg_q;
    row_d = row_q;
    mval_d = mval_q;
    open_d = open_q;
    err_d = err_q;
    bact_d = bact_q;
    bwr_d = bwr_q;
    bap_d = bap_q;
    bbank_d = bbank_q;
    bcol_d = bcol_q;
    dt_d = bact_q ? dt_q + 5'd1 : dt_q;
    dll_d = (dll_q != 8'h00) ? dll_q - 8'h01 : dll_q;
    dq_d = dq_q;
    dqoe_d = 1'b0;
    mwe = 2'b00;
    // Burst engine: beats run from CL-1 edges after the command
    if (bact_q && dt_q >= cl - 5'd1 && beat < bl) begin
      if (bwr_q) begin
        mwe = ~link.dm;
      end else begin
        dq_d = mem_q[idx];
        dqoe_d = 1'b1;
      end
      if (beat == bl - 5'd1) begin
        bact_d = 1'b0;
        if (bap_q) begin
          open_d[bbank_q] = 1'b0;
        end
      end
    end
    unique case (pwr_q)
      D_ON: begin
        if (cke_prev_q && !link.cke) begin
          if (cmd == dcm_pkg::CMD_REF && open_q == 8'h00) begin
            pwr_d = D_SR;
          end else if (nopish) begin
            pwr_d = D_PD;
          end else begin
            err_d = 1'b1;
          end
        end else if (cke_prev_q && !link.cs_n) begin
          unique case (cmd)
            dcm_pkg::CMD_ACT: begin
              if (open_q[link.ba]) begin
                err_d = 1'b1;
              end else begin
                open_d[link.ba] = 1'b1;
                row_d[link.ba] = link.a;
              end
            end
            dcm_pkg::CMD_RD, dcm_pkg::CMD_WR: begin
              if (!open_q[link.ba] || !mval_q[0] || (link.we_n && dll_q != 8'h00)) begin
                err_d = 1'b1;
              end else begin
                bact_d = 1'b1;
                bwr_d = !link.we_n;
                bap_d = link.a[dcm_pkg::AP_BIT];
                bbank_d = link.ba;
                bcol_d = link.a[9:0];
                dt_d = 5'd0;
              end
            end
            dcm_pkg::CMD_PRE: begin
              if (link.a[dcm_pkg::AP_BIT]) begin
                open_d = 8'h00;
              end else begin
                open_d[link.ba] = 1'b0;
              end
            end
            dcm_pkg::CMD_MRS: begin
              if (open_q != 8'h00) begin
                err_d = 1'b1;
              end else begin
                mreg_d[link.ba[1:0]] = link.a;
                mval_d[link.ba[1:0]] = 1'b1;
                if (link.ba == dcm_pkg::SEL_MR && link.a[dcm_pkg::MR_DLLRST_BIT]) begin
                  dll_d = 8'(dcm_pkg::DLL_LOCK_CYC);
                end
              end
            end
            dcm_pkg::CMD_REF: begin
              if (open_q != 8'h00) begin
                err_d = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      D_PD, D_SR: begin
        if (!cke_prev_q && link.cke && nopish) begin
          pwr_d = D_ON;
          if (pwr_q == D_SR) begin
            dll_d = 8'(dcm_pkg::DLL_LOCK_CYC);
          end
        end
      end
      default: pwr_d = D_ON;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_q <= D_ON;
      mreg_q <= '{default: 13'h0000};
      row_q <= '{default: 13'h0000};
      mval_q <= 4'h0;
      open_q <= 8'h00;
      cke_prev_q <= 1'b0;
      err_q <= 1'b0;
      bact_q <= 1'b0;
      bwr_q <= 1'b0;
      bap_q <= 1'b0;
      bbank_q <= 3'h0;
      bcol_q <= 10'h000;
      dt_q <= 5'h00;
      dll_q <= 8'h00;
      dq_q <= 16'h0000;
      dqoe_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      mreg_q <= mreg_d;
      row_q <= row_d;
      mval_q <= mval_d;
      open_q <= open_d;
      cke_prev_q <= link.cke;
      err_q <= err_d;
      bact_q <= bact_d;
      bwr_q <= bwr_d;
      bap_q <= bap_d;
      bbank_q <= bbank_d;
      bcol_q <= bcol_d;
      dt_q <= dt_d;
      dll_q <= dll_d;
      dq_q <= dq_d;
      dqoe_q <= dqoe_d;
    end
  end

  // Write port; array contents have no reset
  always_ff @(posedge clk_i) begin
    if (mwe[0]) begin
      mem_q[idx][7:0] <= link.dq[7:0];
    end
    if (mwe[1]) begin
      mem_q[idx][15:8] <= link.dq[15:8];
    end
  end

  assign link.dev_dq = dq_q;
  assign link.dev_dq_oe = dqoe_q;
  assign mr_o = mreg_q[0];
  assign mr_valid_o = mval_q[0];
  assign pd_o = pwr_q == D_PD;
  assign sr_o = pwr_q == D_SR;
  assign dll_ready_o = dll_q == 8'h00;
  assign err_o = err_q;
endmodule
`default_nettype wire

// >>> verilog/dcm_ctrl.sv
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module dcm_ctrl #(
  parameter int POWER_CYC = dcm_pkg::POWER_CYC_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Link
  dcm_link_if.ctrl link
);
  if (POWER_CYC < 1 || POWER_CYC > 65535) begin : g_chk
    $error("POWER_CYC out of range");
  end

  typedef enum logic [8:0] {
    C_OFF = 9'b000000001, C_POWER = 9'b000000010, C_STEP = 9'b000000100,
    C_WAIT = 9'b000001000, C_READY = 9'b000010000, C_ACT = 9'b000100000,
    C_BURST = 9'b001000000, C_PD = 9'b010000000, C_SR = 9'b100000000
  } dcm_cst_type;

  dcm_cst_type st_q, st_d;
  logic [3:0] step_q, step_d, cmd_q, cmd_d;
  logic [15:0] tmr_q, tmr_d;
  logic [7:0] dll_q, dll_d;
  logic [4:0] t_q, t_d;
  logic cke_q, cke_d, ready_q, ready_d, ack_q, ack_d, dqoe_q, dqoe_d;
  logic [2:0] ba_q, ba_d, op_q, op_d;
  logic [12:0] a_q, a_d;
  logic [1:0] dm_q, dm_d;
  logic [15:0] dq_q, dq_d, wdata_q, wdata_d, rdata_q, rdata_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [25:0] addr_q, addr_d;
  logic [3:0] mode_q, mode_d;
  logic [31:0] rd_q, rd_d;
  logic req, stall, op_load;
  logic [12:0] mr_word;
  logic [4:0] bl;
  logic [3:0] icmd;
  logic [2:0] iba;
  logic [12:0] ia;
  logic [15:0] iwait;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Test mode and DLL reset bits stay zero here
  always_comb begin
    mr_word = 13'h0000;
    mr_word[dcm_pkg::MR_BL_LSB +: 3] = mode_q[2:0];
    mr_word[dcm_pkg::MR_BT_BIT] = mode_q[3];
    mr_word[dcm_pkg::MR_CL_LSB +: 3] = 3'(dcm_pkg::CL_CYC);
    mr_word[dcm_pkg::MR_WR_LSB +: 3] = dcm_pkg::MR_WR_CODE;
  end
  assign bl = (mode_q[2:0] == dcm_pkg::BL_CODE8) ? 5'd8 : 5'd4;

  ////////////////////////////////////////////////////////////////////////////
  // Initialization table
  always_comb begin
    icmd = dcm_pkg::CMD_MRS;
    iba = dcm_pkg::SEL_MR;
    ia = 13'h0000;
    iwait = 16'(dcm_pkg::MRD_CYC);
    unique case (step_q)
      4'd0: begin
        icmd = dcm_pkg::CMD_NOP;
        iwait = 16'(dcm_pkg::CKE_CYC);
      end
      4'd1, 4'd6: begin
        icmd = dcm_pkg::CMD_PRE;
        ia[dcm_pkg::AP_BIT] = 1'b1;
        iwait = 16'(dcm_pkg::RP_CYC);
      end
      4'd2: iba = dcm_pkg::SEL_EMR2;
      4'd3: iba = dcm_pkg::SEL_EMR3;
      4'd4: iba = dcm_pkg::SEL_EMR1;
      4'd5: ia = mr_word | (13'h0001 << dcm_pkg::MR_DLLRST_BIT);
      4'd7, 4'd8: begin
        icmd = dcm_pkg::CMD_REF;
        iwait = 16'(dcm_pkg::RFC_CYC);
      end
      4'd9: ia = mr_word;
      4'd10: begin
        iba = dcm_pkg::SEL_EMR1;
        ia[dcm_pkg::EMR_OCD_LSB +: 3] = dcm_pkg::OCD_DEFAULT;
      end
      default: begin
        iba = dcm_pkg::SEL_EMR1;
        ia[dcm_pkg::EMR_OCD_LSB +: 3] = dcm_pkg::OCD_EXIT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    st_d = st_q;
    step_d = step_q;
    cmd_d = dcm_pkg::CMD_NOP;
    ba_d = 3'h0;
    a_d = 13'h0000;
    cke_d = cke_q;
    tmr_d = (tmr_q != 16'h0000) ? tmr_q - 16'h0001 : tmr_q;
    dll_d = (dll_q != 8'h00) ? dll_q - 8'h01 : dll_q;
    t_d = t_q;
    ready_d = ready_q;
    dq_d = dq_q;
    dqoe_d = 1'b0;
    dm_d = 2'b11;
    rdata_d = rdata_q;
    op_d = op_q;
    if (op_load) begin
      op_d = avs_writedata_i[2:0];
    end
    unique case (st_q)
      C_OFF: begin
        cke_d = 1'b0;
        if (ctrl_q[dcm_pkg::CTRL_INIT_BIT]) begin
          st_d = C_POWER;
          tmr_d = 16'(POWER_CYC);
        end
      end
      C_POWER: begin
        if (tmr_q == 16'h0000) begin
          st_d = C_STEP;
          step_d = 4'd0;
        end
      end
      C_STEP: begin
        if (step_q != 4'd10 || dll_q == 8'h00) begin
          cmd_d = icmd;
          ba_d = iba;
          a_d = ia;
          tmr_d = iwait;
          st_d = C_WAIT;
          if (step_q == 4'd0) begin
            cke_d = 1'b1;
          end
          if (step_q == 4'd5) begin
            dll_d = 8'(dcm_pkg::DLL_LOCK_CYC);
          end
          if (step_q == 4'(dcm_pkg::INIT_LAST)) begin
            ready_d = 1'b1;
          end
        end
      end
      C_WAIT: begin
        if (tmr_q == 16'h0000) begin
          if (ready_q) begin
            st_d = C_READY;
          end else begin
            step_d = step_q + 4'd1;
            st_d = C_STEP;
          end
        end
      end
      C_READY: begin
        if (ctrl_q[dcm_pkg::CTRL_SR_BIT]) begin
          cmd_d = dcm_pkg::CMD_REF;
          cke_d = 1'b0;
          st_d = C_SR;
        end else if (ctrl_q[dcm_pkg::CTRL_PD_BIT]) begin
          cke_d = 1'b0;
          st_d = C_PD;
        end else if (op_q != 3'h0 && dll_q == 8'h00) begin
          cmd_d = dcm_pkg::CMD_ACT;
          ba_d = addr_q[dcm_pkg::ADDR_BANK_LSB +: 3];
          a_d = addr_q[dcm_pkg::ADDR_ROW_LSB +: 13];
          tmr_d = 16'(dcm_pkg::RCD_CYC);
          st_d = C_ACT;
        end
      end
      C_ACT: begin
        if (tmr_q == 16'h0000) begin
          cmd_d = op_q[dcm_pkg::OP_WR_BIT] ? dcm_pkg::CMD_WR : dcm_pkg::CMD_RD;
          ba_d = addr_q[dcm_pkg::ADDR_BANK_LSB +: 3];
          a_d = {2'b00, op_q[dcm_pkg::OP_AP_BIT], addr_q[dcm_pkg::ADDR_COL_LSB +: 10]};
          t_d = 5'd0;
          st_d = C_BURST;
        end
      end
      C_BURST: begin
        t_d = t_q + 5'd1;
        if (op_q[dcm_pkg::OP_WR_BIT]) begin
          if (t_q >= 5'(dcm_pkg::CL_CYC - 1) && t_q < 5'(dcm_pkg::CL_CYC - 1) + bl) begin
            dqoe_d = 1'b1;
            dq_d = wdata_q;
            // Only the first beat carries data; the rest are masked
            dm_d = (t_q == 5'(dcm_pkg::CL_CYC - 1)) ? 2'b00 : 2'b11;
          end
        end else if (t_q == 5'(dcm_pkg::CL_CYC + 1)) begin
          rdata_d = link.dq;
        end
        if (t_q == 5'(dcm_pkg::CL_CYC + dcm_pkg::WR_CYC) + bl) begin
          op_d = 3'h0;
          tmr_d = 16'(dcm_pkg::RP_CYC);
          st_d = C_WAIT;
          if (!op_q[dcm_pkg::OP_AP_BIT]) begin
            cmd_d = dcm_pkg::CMD_PRE;
            ba_d = addr_q[dcm_pkg::ADDR_BANK_LSB +: 3];
          end
        end
      end
      C_PD: begin
        if (!ctrl_q[dcm_pkg::CTRL_PD_BIT]) begin
          cke_d = 1'b1;
          tmr_d = 16'(dcm_pkg::XP_CYC);
          st_d = C_WAIT;
        end
      end
      C_SR: begin
        if (!ctrl_q[dcm_pkg::CTRL_SR_BIT]) begin
          cke_d = 1'b1;
          tmr_d = 16'(dcm_pkg::RFC_CYC);
          dll_d = 8'(dcm_pkg::DLL_LOCK_CYC);
          st_d = C_WAIT;
        end
      end
      default: st_d = C_OFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then answer; a stalled command write waits longer
  assign req = avs_read_i | avs_write_i;
  // A command write stalls while an access is still pending
  assign stall = avs_write_i && avs_address_i == dcm_pkg::REG_CMD && op_q != 3'h0;
  assign ack_d = req & ~ack_q & ~stall;
  // Commands before the device is ready are dropped
  assign op_load = avs_write_i && ack_q && avs_address_i == dcm_pkg::REG_CMD && ready_q &&
                   avs_byteenable_i[0];
  assign avs_waitrequest_o = req & ~ack_q;

  always_comb begin
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    mode_d = mode_q;
    rd_d = rd_q;
    if (avs_write_i && ack_q) begin
      unique case (avs_address_i)
        dcm_pkg::REG_CTRL: ctrl_d = 3'(merge({29'h0, ctrl_q}, avs_writedata_i, avs_byteenable_i));
        dcm_pkg::REG_ADDR: addr_d = 26'(merge({6'h0, addr_q}, avs_writedata_i, avs_byteenable_i));
        dcm_pkg::REG_WDATA: wdata_d = 16'(merge({16'h0, wdata_q}, avs_writedata_i, avs_byteenable_i));
        dcm_pkg::REG_MODE: mode_d = 4'(merge({28'h0, mode_q}, avs_writedata_i, avs_byteenable_i));
        default: begin
        end
      endcase
    end
    if (ack_d && avs_read_i) begin
      unique case (avs_address_i)
        dcm_pkg::REG_CTRL: rd_d = {29'h0, ctrl_q};
        dcm_pkg::REG_STATUS: rd_d = {28'h0, st_q == C_SR, st_q == C_PD, op_q != 3'h0, ready_q};
        dcm_pkg::REG_ADDR: rd_d = {6'h0, addr_q};
        dcm_pkg::REG_WDATA: rd_d = {16'h0, wdata_q};
        dcm_pkg::REG_RDATA: rd_d = {16'h0, rdata_q};
        dcm_pkg::REG_CMD: rd_d = {29'h0, op_q};
        dcm_pkg::REG_MODE: rd_d = {28'h0, mode_q};
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= C_OFF;
      step_q <= 4'h0;
      cmd_q <= dcm_pkg::CMD_NOP;
      ba_q <= 3'h0;
      a_q <= 13'h0000;
      cke_q <= 1'b0;
      tmr_q <= 16'h0000;
      dll_q <= 8'h00;
      t_q <= 5'h00;
      ready_q <= 1'b0;
      dq_q <= 16'h0000;
      dqoe_q <= 1'b0;
      dm_q <= 2'b11;
      rdata_q <= 16'h0000;
      op_q <= 3'h0;
      ack_q <= 1'b0;
      ctrl_q <= 3'h0;
      addr_q <= 26'h0000000;
      wdata_q <= 16'h0000;
      mode_q <= dcm_pkg::MODE_RST;
      rd_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      step_q <= step_d;
      cmd_q <= cmd_d;
      ba_q <= ba_d;
      a_q <= a_d;
      cke_q <= cke_d;
      tmr_q <= tmr_d;
      dll_q <= dll_d;
      t_q <= t_d;
      ready_q <= ready_d;
      dq_q <= dq_d;
      dqoe_q <= dqoe_d;
      dm_q <= dm_d;
      rdata_q <= rdata_d;
      op_q <= op_d;
      ack_q <= ack_d;
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      mode_q <= mode_d;
      rd_q <= rd_d;
    end
  end

  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_q;
  assign link.cke = cke_q;
  assign link.odt = 1'b0;
  assign link.ba = ba_q;
  assign link.a = a_q;
  assign link.dm = dm_q;
  assign link.ctrl_dq = dq_q;
  assign link.ctrl_dq_oe = dqoe_q;
  assign avs_readdata_o = rd_q;
endmodule
`default_nettype wire

// >>> dv/dcm_link_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dcm_link_chk #(
  parameter int POWER_CYC = 10000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic odt,
  input wire logic [2:0] ba,
  input wire logic [12:0] a
);
  logic [3:0] cmd;
  logic idle, mrs, seen_q, up_q;
  logic [2:0] nmrs_q, nref_q;
  logic [15:0] t_q, dll_q;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign idle = cs_n || cmd == dcm_pkg::CMD_NOP;
  assign mrs = cmd == dcm_pkg::CMD_MRS;
  // Counters saturate so a long run cannot wrap into a false pass
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {seen_q, up_q, nmrs_q, nref_q, t_q, dll_q} <= '0;
    end else begin
      seen_q <= seen_q | !idle;
      up_q <= up_q | cke;
      nmrs_q <= nmrs_q + 3'(mrs && nmrs_q < 3'h7);
      nref_q <= nref_q + 3'(cmd == dcm_pkg::CMD_REF && cke && nref_q < 3'h7);
      t_q <= t_q + 16'(t_q < 16'hffff);
      dll_q <= (mrs && ba == 3'h0 && a[8]) ? 16'h0 : dll_q + 16'(dll_q < 16'hffff);
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence idle_s;
    idle;
  endsequence
  property mrs_p(int n, logic ok);
    mrs && nmrs_q == n |-> ok;
  endproperty
  odt_low_a: assert property (!odt)
    else $error("termination enabled");
  power_wait_a: assert property ($rose(cke) && !up_q |-> t_q >= POWER_CYC)
    else $error("clock enable raised early");
  first_cmd_a: assert property (!idle && !seen_q |-> cmd == dcm_pkg::CMD_PRE && a[10]
    && t_q >= POWER_CYC + dcm_pkg::CKE_CYC) else $error("bad first command");
  emr_order_a: assert property (mrs && nmrs_q < 2 |-> ba == nmrs_q + 3'h2)
    else $error("extended register order");
  dll_on_a: assert property (mrs_p(2, ba == 3'h1 && !a[0]))
    else $error("dll enable wrong");
  dll_rst_a: assert property (mrs_p(3, ba == 3'h0 && a[8:7] == 2'h2))
    else $error("dll reset wrong");
  mode_run_a: assert property (mrs_p(4, ba == 3'h0 && a[8:7] == 2'h0 && nref_q >= 2))
    else $error("operating mode write wrong");
  ocd_steps_a: assert property (mrs && (nmrs_q == 5 || nmrs_q == 6) |-> ba == 3'h1
    && a[9:7] == {3{nmrs_q == 5}} && dll_q >= 200) else $error("calibration step wrong");
  mrs_gap_a: assert property (mrs |-> $past(cke) ##1 idle_s)
    else $error("mode write spacing");
  cke_up_a: assert property ($rose(cke) |-> idle)
    else $error("command on enable rise");
  cke_down_a: assert property ($fell(cke) |-> idle || cmd == dcm_pkg::CMD_REF)
    else $error("command on enable fall");
  read_lock_a: assert property (cmd == dcm_pkg::CMD_RD |-> dll_q >= 200)
    else $error("read before lock");
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int PCYC = 50;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [12:0] mr;
  logic wait_s, mr_ok, pd, sr, dll_ok, err;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  dcm_link_if lnk ();
  dcm_ctrl #(.POWER_CYC(PCYC)) u_dcm_ctrl (.clk_i(clk_i), .resetn_i(resetn_i),
    .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_s), .link(lnk));
  dcm_dram u_dcm_dram (.clk_i(clk_i), .resetn_i(resetn_i), .link(lnk), .mr_o(mr),
    .mr_valid_o(mr_ok), .pd_o(pd), .sr_o(sr), .dll_ready_o(dll_ok), .err_o(err));
  dcm_link_chk #(.POWER_CYC(PCYC)) u_dcm_link_chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n), .cke(lnk.cke),
    .odt(lnk.odt), .ba(lnk.ba), .a(lnk.a));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // Values read right after the edge are those the design showed at that edge
  task automatic bus(input logic [4:0] ad, input logic w, input logic [31:0] d,
      output logic [31:0] q);
    adr <= ad;
    wdat <= d;
    wr_s <= w;
    rd_s <= !w;
    do begin
      @(posedge clk_i);
    end while (wait_s !== 1'b0);
    q = rdat;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic poll(input logic [4:0] ad, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    int n = 0;
    do begin
      bus(ad, 1'b0, 32'h0, q);
      n++;
    end while ((q & m) != v && n < 3000);
    chk(q & m, v);
  endtask
  task automatic op(input logic [31:0] ad, input logic [2:0] c, input logic [31:0] d,
      output logic [31:0] q);
    bus(dcm_pkg::REG_ADDR, 1'b1, ad, q);
    bus(dcm_pkg::REG_WDATA, 1'b1, d, q);
    bus(dcm_pkg::REG_CMD, 1'b1, 32'(c), q);
    poll(dcm_pkg::REG_CMD, 32'h7, 32'h0);
    bus(dcm_pkg::REG_RDATA, 1'b0, 32'h0, q);
  endtask
  ////////////////////////////////////////
  initial begin
    logic [31:0] q;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    bus(dcm_pkg::REG_MODE, 1'b0, 32'h0, q);
    chk(q, 32'h2);
    chk(32'(mr_ok), 32'h0);
    bus(5'h1c, 1'b1, 32'hff, q);
    bus(5'h1c, 1'b0, 32'h0, q);
    chk(q, 32'h0);
    $display("test registers done");
    bus(dcm_pkg::REG_MODE, 1'b1, 32'hb, q);
    bus(dcm_pkg::REG_CTRL, 1'b1, 32'h1, q);
    poll(dcm_pkg::REG_STATUS, 32'h1, 32'h1);
    chk(32'(mr[8:0]), {25'h0, 3'(dcm_pkg::CL_CYC), 4'hb});
    chk(32'({mr_ok, dll_ok, err}), 32'h6);
    $display("test init done");
    // Interleaved burst from column 5 would spill onto column 4 if masks failed
    for (int i = 0; i < 2; i++) begin
      for (int c = 0; c < 4; c++) begin
        op({6'h0, 3'(i), 13'h005, 10'(4 + c % 2)}, 3'((c < 2 ? 2 : 1) + 4 * i),
          32'(16'h5a00 + i * 2 + c % 2), q);
        if (c > 1) begin
          chk(q & 32'hffff, 32'(16'h5a00 + i * 2 + c % 2));
        end
      end
    end
    $display("test data done");
    for (int i = 1; i < 3; i++) begin
      bus(dcm_pkg::REG_CTRL, 1'b1, 32'(1 << i), q);
      poll(dcm_pkg::REG_STATUS, 32'(2 << i), 32'(2 << i));
      chk(32'({pd, sr}), 32'(3 - i));
      bus(dcm_pkg::REG_CTRL, 1'b1, 32'h0, q);
      poll(dcm_pkg::REG_STATUS, 32'hc, 32'h0);
      op({6'h0, 3'h1, 13'h005, 10'h005}, 3'h1, 32'h0, q);
      chk(q & 32'hffff, 32'h5a03);
      $display("test low power %0d done", i);
    end
    chk(32'(err), 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
